// >>> dac_cfg_checker_asserts.sv
module dac_cfg_checker
	import dac_cfg_pkg::*;
#(
	parameter logic [7:0] part_id_value = 8'h5c // Arbitrary value
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [dac_cfg_pkg::addr_w-1:0] reg_addr,
	input wire logic [dac_cfg_pkg::data_w-1:0] reg_wdata,
	input wire logic [dac_cfg_pkg::data_w-1:0] reg_rdata,
	input wire logic [9:0] fullscale_code,
	input wire logic [2:0] bandgap_trim_code,
	input wire logic [2:0] sensor_range_bias,
	input wire logic [2:0] sensor_ref_bias,
	input wire logic sensor_enable,
	input wire logic [7:0] irq_setup_value,
	input wire logic irq_normal,
	input wire logic align_enable,
	input wire logic align_falling_edge,
	input wire logic frame_armed
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_fs_low; reg_wr && reg_addr == off_fs_low |=> fullscale_code[7:0] == $past(reg_wdata); endproperty
	a_fs_low: assert property (p_fs_low) else $error("fs low mismatch");
	property p_fs_up; reg_wr && reg_addr == off_fs_upper |=>
		{bandgap_trim_code, fullscale_code[9:8]} == {$past(reg_wdata[7:5]), $past(reg_wdata[1:0])}; endproperty
	a_fs_up: assert property (p_fs_up) else $error("fs upper mismatch");
	property p_sensor; reg_wr && reg_addr == off_temp_ctrl |=>
		{sensor_range_bias, sensor_ref_bias, sensor_enable} == $past(reg_wdata[6:0]); endproperty
	a_sensor: assert property (p_sensor) else $error("sensor fields mismatch");
	property p_irq; reg_wr && reg_addr == off_irq_setup |=> irq_setup_value == $past(reg_wdata)
		&& irq_normal == ($past(reg_wdata) == irq_normal_mode); endproperty
	a_irq: assert property (p_irq) else $error("irq mode mismatch");
	property p_align; reg_wr && reg_addr == off_align_ctrl |=>
		{align_falling_edge, align_enable} == $past(reg_wdata[1:0]); endproperty
	a_align: assert property (p_align) else $error("align mismatch");
	property p_part_id; reg_rd && reg_addr == off_part_id |=> reg_rdata == part_id_value; endproperty
	a_part_id: assert property (p_part_id) else $error("part id mismatch");
	property p_unmapped; reg_rd && reg_addr > off_frame_ctrl |=> reg_rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_reset; disable iff (1'b0) rst |=> fullscale_code == 10'h1f9 && bandgap_trim_code == 3'h7
		&& sensor_ref_bias == 3'h1 && !sensor_enable && !align_enable && frame_armed
		&& sensor_range_bias == 3'h0 && irq_setup_value == 8'h00 && !align_falling_edge; endproperty
	a_reset: assert property (p_reset) else $error("reset state mismatch");
endmodule // dac_cfg_checker

bind dac_misc_config_registers dac_cfg_checker #(.part_id_value(part_id_value)) chk_u (.*);

// >>> dac_cfg_pkg.sv
package dac_cfg_pkg;
	localparam int addr_w = 7;
	localparam int data_w = 8;
	localparam logic [6:0] off_fs_low = 7'h18;
	localparam logic [6:0] off_fs_upper = 7'h19;
	localparam logic [6:0] off_temp_ctrl = 7'h1c;
	localparam logic [6:0] off_temp_low = 7'h1d;
	localparam logic [6:0] off_temp_high = 7'h1e;
	localparam logic [6:0] off_part_id = 7'h1f;
	localparam logic [6:0] off_irq_setup = 7'h20;
	localparam logic [6:0] off_align_ctrl = 7'h21;
	localparam logic [6:0] off_frame_ctrl = 7'h22;
	localparam logic [7:0] rst_fs_low = 8'hf9;
	localparam logic [7:0] rst_fs_upper = 8'he1;
	localparam logic [7:0] rst_temp_ctrl = 8'h02;
	localparam logic [7:0] rst_irq_setup = 8'h00;
	localparam logic [7:0] rst_align_ctrl = 8'h00;
	localparam logic [7:0] rst_frame_ctrl = 8'h12;
	localparam logic [15:0] rst_temp = 16'h0000;
	localparam logic [7:0] rst_rdata = 8'h00;
	localparam logic rst_armed = 1'b1;
	localparam int frame_sync_stages = 2;
	localparam logic [7:0] mask_fs_upper = 8'he3;
	localparam logic [7:0] mask_temp_ctrl = 8'h7f;
	localparam logic [7:0] mask_align_ctrl = 8'h03;
	localparam logic [7:0] mask_frame_ctrl = 8'h0f;
	localparam int trim_lsb = 5;
	localparam int range_lsb = 4;
	localparam int refc_lsb = 1;
	localparam int sensor_en_bit = 0;
	localparam int edge_sel_bit = 1;
	localparam int align_en_bit = 0;
	localparam int arm_bit = 3;
	localparam int continuous_bit = 2;
	localparam logic [1:0] target_fifo = 2'b10;
	localparam logic [1:0] target_none = 2'b11;
	localparam logic [7:0] irq_test_mode = 8'h00;
	localparam logic [7:0] irq_normal_mode = 8'h01;
endpackage

// >>> dac_misc_config_registers.sv
// Operation
// [RL1] Full-scale code bits 9:8 sit in upper register bits 1:0; code resets to 0x1F9
// [RL2] Full-scale code low byte at 0x18, read-write, resets to 0xF9
// [RL3] Bandgap trim in upper register bits 7:5, read-write, resets to 7
// [RL4] Sensor range-current select in bits 6:4, read-write, resets to 0
// [RL5] Sensor reference-current select in bits 3:1, read-write, resets to 1
// [RL6] Sensor enable in bit 0, resets off
// [RL7] Read-only 16-bit temperature at 0x1D low, 0x1E high, zero after reset
// [RL8] Read-only part identifier at 0x1F, writes ignored
// [RL9] Interrupt setup register: 0x00 test mode, 0x01 normal operation
// [RL10] Align control bit 1 picks converter clock edge: 0 rising, 1 falling
// [RL11] Align control bit 0 enables multichip sync, off after reset
// [RL12] Mode bit 2 clear acts once per arm; set acts on every frame
// [RL13] One-shot frame response is the reset state
// [RL14] Writing 1 to bit 3 re-arms one-shot response
// [RL15] Target bits 1:0: 10 restarts FIFO, 11 restarts nothing; reset 10
// [RL16] Reset loads 0xE1, 0x02 and 0x12 into the three control registers
// [RL17] Undefined bits read zero and ignore writes; frame control bit 4 reads 1 after reset (0x12) until the register is written
module dac_misc_config_registers
	import dac_cfg_pkg::*;
#(
	parameter logic [7:0] part_id_value = 8'h5c // Arbitrary value
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [dac_cfg_pkg::addr_w-1:0] reg_addr,
	input wire logic [dac_cfg_pkg::data_w-1:0] reg_wdata,
	output logic [dac_cfg_pkg::data_w-1:0] reg_rdata,
	input wire logic temp_valid,
	input wire logic [15:0] temp_value,
	input wire logic frame_pin,
	output logic [9:0] fullscale_code,
	output logic [2:0] bandgap_trim_code,
	output logic [2:0] sensor_range_bias,
	output logic [2:0] sensor_ref_bias,
	output logic sensor_enable,
	output logic [7:0] irq_setup_value,
	output logic irq_normal,
	output logic align_enable,
	output logic align_falling_edge,
	output logic fifo_restart,
	output logic frame_armed
);
	//--------------------------------------------------
	// Register state
	//--------------------------------------------------
	logic [7:0] fs_low_reg, fs_low_next;
	logic [7:0] fs_upper_reg, fs_upper_next;
	logic [7:0] temp_ctrl_reg, temp_ctrl_next;
	logic [15:0] temp_reg, temp_next;
	logic [7:0] irq_setup_reg, irq_setup_next;
	logic [7:0] align_reg, align_next;
	logic [7:0] frame_reg, frame_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [frame_sync_stages:0] frame_sync_reg, frame_sync_next;
	logic wr_fs_low, wr_fs_upper, wr_temp_ctrl;
	logic wr_irq_setup, wr_align, wr_frame;
	logic frame_edge;
	logic arm_pulse;

	//--------------------------------------------------
	// Parameter checks
	//--------------------------------------------------
	if (addr_w != 7)
	begin : g_bad_addr_w
		$error("Offset width must be 7 bits");
	end

	if (data_w != 8)
	begin : g_bad_data_w
		$error("Data width must be 8 bits");
	end

	if (frame_sync_stages < 2)
	begin : g_bad_sync
		$error("Frame pin needs at least two synchroniser stages");
	end

	if (trim_lsb + 3 > data_w || range_lsb + 3 > data_w)
	begin : g_bad_field
		$error("Field positions exceed the data width");
	end

	//--------------------------------------------------
	// Write decode
	//--------------------------------------------------
	function automatic logic wr_hit(
		input logic wr,
		input logic [6:0] addr,
		input logic [6:0] off
	);
		wr_hit = wr && (addr == off);
	endfunction

	assign wr_fs_low = wr_hit(reg_wr, reg_addr, off_fs_low); // RL2
	assign wr_fs_upper = wr_hit(reg_wr, reg_addr, off_fs_upper);
	assign wr_temp_ctrl = wr_hit(reg_wr, reg_addr, off_temp_ctrl);
	assign wr_irq_setup = wr_hit(reg_wr, reg_addr, off_irq_setup); // RL9
	assign wr_align = wr_hit(reg_wr, reg_addr, off_align_ctrl);
	assign wr_frame = wr_hit(reg_wr, reg_addr, off_frame_ctrl);
	assign arm_pulse = wr_frame && reg_wdata[arm_bit]; // RL14

	//--------------------------------------------------
	// Full-scale and trim registers
	//--------------------------------------------------
	always_comb
	begin
		fs_low_next = fs_low_reg;
		fs_upper_next = fs_upper_reg;
		if (wr_fs_low)
			fs_low_next = reg_wdata; // RL2
		if (wr_fs_upper)
			fs_upper_next = reg_wdata & mask_fs_upper; // RL1 RL3 RL17
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			fs_low_reg <= rst_fs_low; // RL2
			fs_upper_reg <= rst_fs_upper; // RL16
		end
		else
		begin
			fs_low_reg <= fs_low_next;
			fs_upper_reg <= fs_upper_next;
		end
	end

	//--------------------------------------------------
	// Sensor control register
	//--------------------------------------------------
	always_comb
	begin
		temp_ctrl_next = temp_ctrl_reg;
		if (wr_temp_ctrl)
			temp_ctrl_next = reg_wdata & mask_temp_ctrl; // RL4 RL5 RL6 RL17
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			temp_ctrl_reg <= rst_temp_ctrl; // RL16
		else
			temp_ctrl_reg <= temp_ctrl_next;
	end

	//--------------------------------------------------
	// Temperature result
	//--------------------------------------------------
	always_comb
	begin
		temp_next = temp_reg;
		if (temp_valid && temp_ctrl_reg[sensor_en_bit])
			temp_next = temp_value; // RL7
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			temp_reg <= rst_temp; // RL7
		else
			temp_reg <= temp_next;
	end

	//--------------------------------------------------
	// Interrupt setup register
	//--------------------------------------------------
	always_comb
	begin
		irq_setup_next = irq_setup_reg;
		if (wr_irq_setup)
			irq_setup_next = reg_wdata; // RL9
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			irq_setup_reg <= rst_irq_setup;
		else
			irq_setup_reg <= irq_setup_next;
	end

	//--------------------------------------------------
	// Multichip align register
	//--------------------------------------------------
	always_comb
	begin
		align_next = align_reg;
		if (wr_align)
			align_next = reg_wdata & mask_align_ctrl; // RL10 RL11 RL17
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			align_reg <= rst_align_ctrl; // RL11
		else
			align_reg <= align_next;
	end

	//--------------------------------------------------
	// Frame restart control register
	//--------------------------------------------------
	always_comb
	begin
		frame_next = frame_reg;
		if (wr_frame)
			frame_next = reg_wdata & mask_frame_ctrl; // RL17
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			frame_reg <= rst_frame_ctrl; // RL16 RL13
		else
			frame_reg <= frame_next;
	end

	//--------------------------------------------------
	// Frame pin synchroniser
	//--------------------------------------------------
	for (genvar i = 0; i <= frame_sync_stages; i++)
	begin : g_frame_sync
		if (i == 0)
		begin : g_first
			assign frame_sync_next[i] = frame_pin;
		end
		else
		begin : g_chain
			assign frame_sync_next[i] = frame_sync_reg[i-1];
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			frame_sync_reg <= '0;
		else
			frame_sync_reg <= frame_sync_next;
	end

	assign frame_edge = frame_sync_reg[frame_sync_stages-1] && !frame_sync_reg[frame_sync_stages];

	//--------------------------------------------------
	// Read path
	//--------------------------------------------------
	always_comb
	begin
		rdata_next = rdata_reg;
		if (reg_rd)
		begin
			unique case (reg_addr)
				off_fs_low: rdata_next = fs_low_reg;
				off_fs_upper: rdata_next = fs_upper_reg;
				off_temp_ctrl: rdata_next = temp_ctrl_reg;
				off_temp_low: rdata_next = temp_reg[7:0]; // RL7
				off_temp_high: rdata_next = temp_reg[15:8]; // RL7
				off_part_id: rdata_next = part_id_value; // RL8
				off_irq_setup: rdata_next = irq_setup_reg;
				off_align_ctrl: rdata_next = align_reg;
				off_frame_ctrl: rdata_next = frame_reg;
				default: rdata_next = 8'h00; // RL17
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			rdata_reg <= rst_rdata;
		else
			rdata_reg <= rdata_next;
	end

	//--------------------------------------------------
	// Frame restart
	//--------------------------------------------------
	frame_restart_gate u_gate (
		.clk(clk),
		.rst(rst),
		.frame_valid(frame_edge),
		.continuous_frame_restart(frame_reg[continuous_bit]), // RL12
		.arm_pulse(arm_pulse),
		.restart_target(frame_reg[1:0]), // RL15
		.fifo_restart(fifo_restart),
		.armed(frame_armed)
	);

	//--------------------------------------------------
	// Outputs
	//--------------------------------------------------
	assign reg_rdata = rdata_reg;
	assign fullscale_code = {fs_upper_reg[1:0], fs_low_reg}; // RL1
	assign bandgap_trim_code = fs_upper_reg[trim_lsb +: 3]; // RL3
	assign sensor_range_bias = temp_ctrl_reg[range_lsb +: 3]; // RL4
	assign sensor_ref_bias = temp_ctrl_reg[refc_lsb +: 3]; // RL5
	assign sensor_enable = temp_ctrl_reg[sensor_en_bit]; // RL6
	assign irq_setup_value = irq_setup_reg;
	assign irq_normal = (irq_setup_reg == irq_normal_mode); // RL9
	assign align_enable = align_reg[align_en_bit]; // RL11
	assign align_falling_edge = align_reg[edge_sel_bit]; // RL10
endmodule // dac_misc_config_registers

// >>> frame_restart_gate.sv
module frame_restart_gate
	import dac_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic frame_valid,
	input wire logic continuous_frame_restart,
	input wire logic arm_pulse,
	input wire logic [1:0] restart_target,
	output logic fifo_restart,
	output logic armed
);
	logic armed_reg;
	logic armed_next;
	logic act;

	always_comb
	begin
		act = frame_valid && (continuous_frame_restart || armed_reg);
		armed_next = armed_reg;
		if (act && !continuous_frame_restart)
			armed_next = 1'b0; // RL12
		if (arm_pulse)
			armed_next = 1'b1; // RL14
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			armed_reg <= rst_armed; // RL13
		else
			armed_reg <= armed_next;
	end

	assign fifo_restart = act && (restart_target == target_fifo); // RL15
	assign armed = armed_reg;
endmodule // frame_restart_gate

// >>> tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dac_cfg_pkg::*;
	localparam logic [7:0] pid = 8'h3b; // Arbitrary value
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, temp_valid = 1'b0, frame_pin = 1'b0;
	logic [6:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0, reg_rdata, d;
	logic [15:0] temp_value = '0;
	logic irq_normal, fifo_restart;
	logic [9:0] fullscale_code;
	logic [2:0] bandgap_trim_code, sensor_range_bias, sensor_ref_bias;
	logic [7:0] irq_setup_value;
	logic sensor_enable, align_enable, align_falling_edge, frame_armed;
	logic [6:0] wa [6] = '{7'h18, 7'h19, 7'h1c, 7'h20, 7'h21, 7'h22};
	logic [31:0] seed = 32'h359359b7, v;
	int n_errors = 0, tests_run = 0;
	logic [6:0] ra [9] = '{7'h18, 7'h19, 7'h1c, 7'h1d, 7'h1e, 7'h1f, 7'h20, 7'h21, 7'h22};
	logic [7:0] rv [9] = '{8'hf9, 8'he1, 8'h02, 8'h00, 8'h00, pid, 8'h00, 8'h00, 8'h12};
	always #25 clk = ~clk;
	dac_misc_config_registers #(.part_id_value(pid)) dut_u (.clk(clk), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.temp_valid(temp_valid), .temp_value(temp_value), .frame_pin(frame_pin),
		.fullscale_code(fullscale_code), .bandgap_trim_code(bandgap_trim_code),
		.sensor_range_bias(sensor_range_bias), .sensor_ref_bias(sensor_ref_bias),
		.sensor_enable(sensor_enable), .irq_setup_value(irq_setup_value), .irq_normal(irq_normal),
		.align_enable(align_enable), .align_falling_edge(align_falling_edge),
		.fifo_restart(fifo_restart), .frame_armed(frame_armed));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic [7:0] msk(logic [6:0] a);
		case (a)
			off_fs_upper: return mask_fs_upper;
			off_temp_ctrl: return mask_temp_ctrl;
			off_align_ctrl: return mask_align_ctrl;
			off_frame_ctrl: return mask_frame_ctrl;
			default: return 8'hff;
		endcase
	endfunction
	task chk(string nm, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("BAD %s exp %h got %h", nm, e, g);
			n_errors++;
		end
	endtask
	task wr(logic [6:0] a, logic [7:0] dd);
		@(posedge clk);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= dd;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(logic [6:0] a, logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", e, reg_rdata);
	endtask
	task frm(int e);
		int c;
		c = 0;
		@(posedge clk);
		frame_pin <= 1'b1;
		repeat (8)
		begin
			@(posedge clk);
			#1 if (fifo_restart === 1'b1) c++;
		end
		@(posedge clk);
		frame_pin <= 1'b0;
		repeat (4) @(posedge clk);
		chk("restarts", e[15:0], c[15:0]);
	endtask
	task finish_test();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
		chk("fullscale_code", 16'h01f9, {6'h00, fullscale_code});
		chk("bandgap_trim_code", 16'h0007, {13'h0, bandgap_trim_code});
		chk("sensor_range_bias", 16'h0000, {13'h0, sensor_range_bias});
		chk("sensor_ref_bias", 16'h0001, {13'h0, sensor_ref_bias});
		chk("sensor_enable", 16'h0000, {15'h0, sensor_enable});
		frm(1);
		#1 chk("frame_armed", 16'h0000, {15'h0, frame_armed});
		frm(0);
		wr(off_frame_ctrl, 8'h0a);
		#1 chk("frame_armed", 16'h0001, {15'h0, frame_armed});
		frm(1);
		wr(off_frame_ctrl, 8'h06);
		frm(1);
		frm(1);
		wr(off_frame_ctrl, 8'h07);
		frm(0);
		for (int i = 0; i < 30; i++)
		begin
			v = rnd();
			d = v[15:8];
			wr(wa[v[2:0] % 6], d);
			rd(wa[v[2:0] % 6], d & msk(wa[v[2:0] % 6]));
		end
		wr(off_temp_ctrl, 8'h03);
		v = rnd();
		@(posedge clk);
		temp_valid <= 1'b1; temp_value <= v[15:0];
		@(posedge clk);
		temp_valid <= 1'b0;
		wr(off_temp_low, ~v[7:0]);
		rd(off_temp_low, v[7:0]);
		rd(off_temp_high, v[15:8]);
		wr(off_part_id, ~pid);
		rd(off_part_id, pid);
		rd(7'h40, 8'h00);
		rd(7'h17, 8'h00);
		rd(7'h1b, 8'h00);
		wr(off_irq_setup, irq_normal_mode);
		#1 chk("irq_normal", 16'h1, {15'h0, irq_normal});
		chk("irq_setup_value", 16'h0001, {8'h00, irq_setup_value});
		wr(off_irq_setup, irq_test_mode);
		#1 chk("irq_normal", 16'h0, {15'h0, irq_normal});
		wr(off_align_ctrl, 8'h03);
		#1 chk("align", 16'h0003, {14'h0, align_falling_edge, align_enable});
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
		chk("align", 16'h0000, {14'h0, align_falling_edge, align_enable});
		frm(1);
		finish_test();
	end
endmodule // tb
